// ===== rtl/sefe_defines.vh
`ifndef SEFE_DEFINES_VH
`define SEFE_DEFINES_VH

// register byte offsets
`define SEFE_REG_CTRL    8'h00
`define SEFE_REG_STATUS  8'h04
`define SEFE_REG_CMD     8'h08
`define SEFE_REG_ADDR    8'h0c
`define SEFE_REG_DATA    8'h10
`define SEFE_REG_RDDATA  8'h14

// axi responses
`define SEFE_RESP_OKAY   2'b00
`define SEFE_RESP_SLVERR 2'b10

// opcodes
`define SEFE_OP_ENABLE_WRITES_CMD     8'h06
`define SEFE_OP_DISABLE_WRITES_CMD     8'h04
`define SEFE_OP_STATUS_READ_CMD     8'h05
`define SEFE_OP_STATUS_WRITE_CMD     8'h01
`define SEFE_OP_READ     8'h03
`define SEFE_OP_WRITE    8'h02
`define SEFE_OP_IDRD     8'h83
`define SEFE_OP_IDWR     8'h82

// status byte fields
`define SEFE_SB_LOCK     7
`define SEFE_SB_BPHI     3
`define SEFE_SB_BPLO     2

// protected region bases
`define SEFE_QTR_BASE    15'h6000
`define SEFE_HALF_BASE   15'h4000
`define SEFE_ID_ABIT     10

// pin indices and synchroniser reset levels {wg,hold,si,cs,sclk}
// chip select resets low so a select already low at reset never arms
`define SEFE_PIN_SCLK    0
`define SEFE_PIN_CS      1
`define SEFE_PIN_SI      2
`define SEFE_PIN_HOLD    3
`define SEFE_PIN_WG      4
`define SEFE_PIN_RST     5'b11000

// byte positions within a frame
`define SEFE_BYTE_OP     3'd0
`define SEFE_BYTE_A1     3'd1
`define SEFE_BYTE_A2     3'd2
`define SEFE_BYTE_D0     3'd3
`define SEFE_BYTE_SAT    3'd4

`endif

// ===== rtl/sefe_top.v
`timescale 1ns/10ps
`include "sefe_defines.vh"

// Operation
// - serial_out changes after shift clock falls
// - input bits captured on shift clock rise
// - deselected: output released, standby unless busy
// - first selection needs a chip select fall
// - pause releases output, freezes bit position
// - pause enters and leaves with clock low
// - deselect during pause aborts the instruction
// - reset clears latch and busy only
// - writes need clock count multiple of eight
// - modifying instructions need write latch set
// - latch cleared by disable, writes, reset
// - execute only on deselect at byte boundary
// - reads exempt from deselect timing check
// - protect bits select blocked array region
// - unknown opcode deselects for rest of frame
// - decode status write, read, write opcodes
// - decode enable, disable, status read opcodes
// - id read: page or lock by address bit
// - id write: page or lock by address bit
// - write guard freezes protect bits while lock bit set
// - busy flag set during write cycles
// - lock plus low guard rejects status write
// - status write ignores b6..b4,b1,b0
module sefe_top #(
  parameter         ADDR_W       = 8,
  parameter [15:0]  WRITE_CYCLES = 16'd1024
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              shift_clock,
  input  wire              chip_select_n,
  input  wire              serial_in,
  input  wire              pause_input_n,
  input  wire              write_guard_n,
  output wire              serial_out,
  output wire              serial_out_oe
);

  // pin synchronisers and glitch filter
  wire [4:0] pin_raw = {write_guard_n, pause_input_n, serial_in,
                        chip_select_n, shift_clock};
  wire [4:0] pin_rst = `SEFE_PIN_RST;
  reg  [4:0] pin_s1_q;
  reg  [4:0] pin_s2_q;
  reg  [4:0] pin_s3_q;
  reg  [4:0] pin_f_q;
  reg  [4:0] pin_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      // three stages, level accepted when stages two and three agree
      always @(posedge aclk) begin
        if (!aresetn) begin
          pin_s1_q[gi]   <= pin_rst[gi];
          pin_s2_q[gi]   <= pin_rst[gi];
          pin_s3_q[gi]   <= pin_rst[gi];
          pin_f_q[gi]    <= pin_rst[gi];
          pin_prev_q[gi] <= pin_rst[gi];
        end else begin
          pin_s1_q[gi]   <= pin_raw[gi];
          pin_s2_q[gi]   <= pin_s1_q[gi];
          pin_s3_q[gi]   <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi])
            pin_f_q[gi] <= pin_s3_q[gi];
          pin_prev_q[gi] <= pin_f_q[gi];
        end
      end
    end
  endgenerate

  wire sclk_f    = pin_f_q[`SEFE_PIN_SCLK];
  wire cs_f      = pin_f_q[`SEFE_PIN_CS];
  wire si_f      = pin_f_q[`SEFE_PIN_SI];
  wire hold_f    = pin_f_q[`SEFE_PIN_HOLD];
  wire wg_f      = pin_f_q[`SEFE_PIN_WG];
  wire sclk_rise = sclk_f & ~pin_prev_q[`SEFE_PIN_SCLK];
  wire sclk_fall = ~sclk_f & pin_prev_q[`SEFE_PIN_SCLK];
  wire cs_rise   = cs_f & ~pin_prev_q[`SEFE_PIN_CS];

  // interface state
  reg        armed_q;
  reg        paused_q;
  reg        abort_q;
  reg [2:0]  bit_cnt_q;
  reg [2:0]  byte_cnt_q;
  reg [7:0]  shreg_q;
  reg [7:0]  opcode_q;
  reg [15:0] addr_q;
  reg [7:0]  data_q;
  reg        out_en_q;
  reg [2:0]  out_bit_q;
  reg        serial_out_q;

  // status and write engine; non-volatile bits keep their value over reset
  reg        latch_q;
  reg        busy_q;
  reg        lock_q    = 1'b0;
  reg [1:0]  bp_q      = 2'b00;
  reg        id_lock_q = 1'b0;
  reg [7:0]  pend_q;
  reg [1:0]  kind_q;
  reg [15:0] wcnt_q;
  reg [7:0]  last_op_q;
  reg [7:0]  exec_cnt_q;
  reg        id_en_q;
  reg [7:0]  rd_data_q;

  localparam [1:0] KIND_ARRAY  = 2'd0;
  localparam [1:0] KIND_STATUS = 2'd1;
  localparam [1:0] KIND_IDPAGE = 2'd2;
  localparam [1:0] KIND_IDLOCK = 2'd3;

  wire       selected  = armed_q & ~cs_f;
  wire       active    = selected & ~paused_q & ~abort_q;
  wire [7:0] in_byte   = {shreg_q[6:0], si_f};
  wire       hard_prot = lock_q & ~wg_f;
  wire [7:0] status_byte = {lock_q, 3'b000, bp_q, latch_q, busy_q};
  wire       id_abit   = addr_q[`SEFE_ID_ABIT];

  // opcode table, id opcodes only on the id variant
  function op_valid;
    input [7:0] op;
    input       id_en;
    begin
      case (op)
        `SEFE_OP_ENABLE_WRITES_CMD, `SEFE_OP_DISABLE_WRITES_CMD, `SEFE_OP_STATUS_READ_CMD,
        `SEFE_OP_STATUS_WRITE_CMD, `SEFE_OP_READ, `SEFE_OP_WRITE: op_valid = 1'b1;
        `SEFE_OP_IDRD, `SEFE_OP_IDWR: op_valid = id_en;
        default: op_valid = 1'b0;
      endcase
    end
  endfunction

  // block protection lookup
  reg prot_hit;
  always @* begin
    case (bp_q)
      2'b01:   prot_hit = (addr_q[14:0] >= `SEFE_QTR_BASE);
      2'b10:   prot_hit = (addr_q[14:0] >= `SEFE_HALF_BASE);
      2'b11:   prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  end

  // byte returned on the output
  reg [7:0] tx_byte;
  always @* begin
    if (opcode_q == `SEFE_OP_STATUS_READ_CMD)
      tx_byte = status_byte;
    else if (opcode_q == `SEFE_OP_IDRD && id_abit)
      tx_byte = {7'b0000000, id_lock_q};
    else
      tx_byte = rd_data_q;
  end

  // selection, pause, shifting
  always @(posedge aclk) begin
    if (!aresetn) begin
      armed_q      <= 1'b0;
      paused_q     <= 1'b0;
      abort_q      <= 1'b0;
      bit_cnt_q    <= 3'd0;
      byte_cnt_q   <= `SEFE_BYTE_OP;
      shreg_q      <= 8'h00;
      opcode_q     <= 8'h00;
      addr_q       <= 16'h0000;
      data_q       <= 8'h00;
      out_en_q     <= 1'b0;
      out_bit_q    <= 3'd0;
      serial_out_q <= 1'b0;
    end else if (cs_f) begin
      armed_q      <= 1'b1;
      paused_q     <= 1'b0;
      abort_q      <= 1'b0;
      bit_cnt_q    <= 3'd0;
      byte_cnt_q   <= `SEFE_BYTE_OP;
      out_en_q     <= 1'b0;
      out_bit_q    <= 3'd0;
      serial_out_q <= 1'b0;
    end else if (armed_q) begin
      if (!sclk_f)
        paused_q <= ~hold_f;
      if (sclk_rise && active) begin
        shreg_q   <= in_byte;
        bit_cnt_q <= bit_cnt_q + 3'd1;
        if (bit_cnt_q == 3'd7) begin
          if (byte_cnt_q != `SEFE_BYTE_SAT)
            byte_cnt_q <= byte_cnt_q + 3'd1;
          case (byte_cnt_q)
            `SEFE_BYTE_OP: begin
              opcode_q <= in_byte;
              if (!op_valid(in_byte, id_en_q))
                abort_q <= 1'b1;
              if (in_byte == `SEFE_OP_STATUS_READ_CMD)
                out_en_q <= 1'b1;
            end
            `SEFE_BYTE_A1: begin
              if (opcode_q == `SEFE_OP_STATUS_WRITE_CMD)
                data_q <= in_byte;
              else
                addr_q[15:8] <= in_byte;
            end
            `SEFE_BYTE_A2: begin
              addr_q[7:0] <= in_byte;
              if (opcode_q == `SEFE_OP_READ || opcode_q == `SEFE_OP_IDRD)
                out_en_q <= 1'b1;
            end
            `SEFE_BYTE_D0: data_q <= in_byte;
            default: ;
          endcase
        end
      end
      if (sclk_fall && active && out_en_q) begin
        serial_out_q <= tx_byte[3'd7 - out_bit_q];
        out_bit_q    <= out_bit_q + 3'd1;
      end
    end
  end

  wire exec = cs_rise & armed_q & ~abort_q & ~paused_q &
              (bit_cnt_q == 3'd0) & (byte_cnt_q != `SEFE_BYTE_OP);
  wire op_only  = (byte_cnt_q == `SEFE_BYTE_A1);
  wire has_data = (byte_cnt_q == `SEFE_BYTE_SAT);

  // instruction execution and self-timed write cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_q    <= 1'b0;
      busy_q     <= 1'b0;
      pend_q     <= 8'h00;
      kind_q     <= KIND_ARRAY;
      wcnt_q     <= 16'h0000;
      last_op_q  <= 8'h00;
      exec_cnt_q <= 8'h00;
    end else begin
      if (busy_q) begin
        if (wcnt_q == WRITE_CYCLES - 16'd1) begin
          busy_q  <= 1'b0;
          wcnt_q  <= 16'h0000;
          latch_q <= 1'b0;
          if (kind_q == KIND_STATUS) begin
            lock_q <= pend_q[`SEFE_SB_LOCK];
            bp_q   <= {pend_q[`SEFE_SB_BPHI], pend_q[`SEFE_SB_BPLO]};
          end
          if (kind_q == KIND_IDLOCK)
            id_lock_q <= 1'b1;
        end else begin
          wcnt_q <= wcnt_q + 16'd1;
        end
      end
      if (exec) begin
        last_op_q  <= opcode_q;
        exec_cnt_q <= exec_cnt_q + 8'd1;
        case (opcode_q)
          `SEFE_OP_ENABLE_WRITES_CMD: if (op_only) latch_q <= 1'b1;
          `SEFE_OP_DISABLE_WRITES_CMD: if (op_only) latch_q <= 1'b0;
          `SEFE_OP_STATUS_WRITE_CMD: begin
            if (byte_cnt_q == `SEFE_BYTE_A2 && latch_q && !hard_prot &&
                !busy_q) begin
              busy_q <= 1'b1;
              kind_q <= KIND_STATUS;
              pend_q <= data_q;
            end
          end
          `SEFE_OP_WRITE: begin
            if (has_data && latch_q && !busy_q && !prot_hit) begin
              busy_q <= 1'b1;
              kind_q <= KIND_ARRAY;
            end
          end
          `SEFE_OP_IDWR: begin
            if (has_data && latch_q && !busy_q && !id_lock_q) begin
              busy_q <= 1'b1;
              kind_q <= id_abit ? KIND_IDLOCK : KIND_IDPAGE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign serial_out    = serial_out_q;
  assign serial_out_oe = out_en_q & active;

  // axi4-lite write channel
  reg              aw_hold_q;
  reg              w_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0]       wdata_q;
  reg              wstrb0_q;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;

  wire [7:0] waddr8 = awaddr_q[7:0];
  wire       w_map  = (waddr8 == `SEFE_REG_CTRL) ||
                      (waddr8 == `SEFE_REG_RDDATA);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= {ADDR_W{1'b0}};
      wdata_q      <= 32'h00000000;
      wstrb0_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SEFE_RESP_OKAY;
      id_en_q      <= 1'b0;
      rd_data_q    <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      // commit when both halves held
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? `SEFE_RESP_OKAY : `SEFE_RESP_SLVERR;
        if (wstrb0_q && waddr8 == `SEFE_REG_CTRL)
          id_en_q <= wdata_q[0];
        if (wstrb0_q && waddr8 == `SEFE_REG_RDDATA)
          rd_data_q <= wdata_q[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  assign s_axi_arready = ~s_axi_rvalid;

  wire       standby = ~selected & ~busy_q;
  wire [7:0] raddr8  = s_axi_araddr[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SEFE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SEFE_RESP_OKAY;
      case (raddr8)
        `SEFE_REG_CTRL:   s_axi_rdata <= {31'h00000000, id_en_q};
        `SEFE_REG_STATUS: s_axi_rdata <= {20'h00000, standby, id_lock_q,
                                          paused_q, selected, status_byte};
        `SEFE_REG_CMD:    s_axi_rdata <= {16'h0000, exec_cnt_q, last_op_q};
        `SEFE_REG_ADDR:   s_axi_rdata <= {16'h0000, addr_q};
        `SEFE_REG_DATA:   s_axi_rdata <= {24'h000000, data_q};
        `SEFE_REG_RDDATA: s_axi_rdata <= {24'h000000, rd_data_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SEFE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // sefe_top

// ===== tb/sefe_checker.sv
`timescale 1ns/10ps
module sefe_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        shift_clock,
  input wire        chip_select_n,
  input wire        pause_input_n,
  input wire        serial_out,
  input wire        serial_out_oe
);
  logic       sclk_q;
  logic [3:0] fall_age_q;
  logic [3:0] rise_age_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // age in cycles of the last shift clock fall and rise
  always @(posedge aclk) begin
    sclk_q <= shift_clock;
    if (!aresetn) fall_age_q <= 4'hf;
    else if (sclk_q && !shift_clock) fall_age_q <= 4'h0;
    else if (fall_age_q != 4'hf) fall_age_q <= fall_age_q + 4'h1;
    if (!aresetn) rise_age_q <= 4'hf;
    else if (!sclk_q && shift_clock) rise_age_q <= 4'h0;
    else if (rise_age_q != 4'hf) rise_age_q <= rise_age_q + 4'h1;
  end

  sequence desel_s; chip_select_n [*6]; endsequence
  sequence paused_s; (!pause_input_n && !shift_clock) [*8]; endsequence

  deselect_release_a: assert property (desel_s |-> !serial_out_oe)
    else $error("output driven while deselected");
  pause_release_a: assert property (paused_s |-> !serial_out_oe)
    else $error("output driven while paused");
  out_after_fall_a: assert property ($changed(serial_out) && serial_out_oe
    && $past(serial_out_oe) |-> fall_age_q <= 4'd6)
    else $error("output changed away from a clock fall");
  drive_after_rise_a: assert property ($rose(serial_out_oe)
    && $past(pause_input_n, 8) |-> rise_age_q <= 4'd6)
    else $error("output enabled away from a clock rise");
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !serial_out_oe)
    else $error("outputs not idle after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule // sefe_checker

bind sefe_top sefe_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .shift_clock,
  .chip_select_n, .pause_input_n, .serial_out, .serial_out_oe);

// ===== tb/sefe_spi_master.sv
`timescale 1ns/10ps
module sefe_spi_master (
  output logic shift_clock,
  output logic chip_select_n,
  output logic serial_in,
  output logic pause_input_n,
  input  wire  serial_out,
  input  wire  serial_out_oe
);
  logic so_last;
  // a released line shows the inverse of its last driven level
  wire  so_line = serial_out_oe ? serial_out : ~so_last;
  always @(serial_out or serial_out_oe)
    if (serial_out_oe) so_last = serial_out;

  initial begin
    shift_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    pause_input_n = 1'b1;
    so_last = 1'b0;
  end

  // one frame, msb first; md[0] pause at bit 4, md[1] deselect in pause
  task xfer(input logic [31:0] tx, input int nb, input logic [1:0] md,
            output logic [31:0] rx);
    int i;
    int k;
    rx = 32'h0;
    #3 chip_select_n = 1'b0;
    #40;
    for (i = 0; i < nb; i++) begin
      serial_in = tx[nb-1-i];
      if (md != 2'd0 && i == 4) begin
        // pause entered while selected, clock low
        pause_input_n = 1'b0;
        for (k = 0; k < 6; k++) begin
          #32 shift_clock = ~shift_clock;
          serial_in = ~serial_in;
        end
        #40;
        if (md[1]) chip_select_n = 1'b1;
        #40 pause_input_n = 1'b1;
        serial_in = tx[nb-1-i];
        #40;
      end
      // bit held across the rising edge
      #32 shift_clock = 1'b1;
      #32 rx = {rx[30:0], so_line};
      shift_clock = 1'b0;
    end
    // deselect after the last fall, clock stopped
    #16 chip_select_n = 1'b1;
    #80;
  endtask
endmodule // sefe_spi_master

// ===== tb/sefe_top_tb.sv
`timescale 1ns/10ps
module sefe_top_tb;
  typedef struct {logic [4:0] f; logic [31:0] tx; int nb;
                  logic [7:0] ex;} sefe_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, write_guard_n;
  logic shift_clock, chip_select_n, serial_in, pause_input_n;
  logic serial_out, serial_out_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, m;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, rx;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          i, checks, n_mismatch;
  // flags: 1 busy only, 2 pause, 4 deselect in pause, 8 guard low, 10 bits
  sefe_row_t rows [27] = '{
    '{5'h00, 32'h06, 8, 8'h02}, '{5'h00, 32'h04, 8, 8'h00},
    '{5'h00, 32'h06, 8, 8'h02}, '{5'h00, 32'h018c, 16, 8'h8c},
    '{5'h00, 32'h06, 8, 8'h8e}, '{5'h00, 32'h0173, 16, 8'h00},
    '{5'h00, 32'h06, 8, 8'h02}, '{5'h00, 32'h0082, 15, 8'h02},
    '{5'h00, 32'h0208, 17, 8'h02}, '{5'h00, 32'h0108, 16, 8'h08},
    '{5'h00, 32'hff06, 16, 8'h08},
    '{5'h01, 32'h02100055, 32, 8'h00}, '{5'h00, 32'h06, 8, 8'h0a},
    '{5'h01, 32'h02400055, 32, 8'h00}, '{5'h00, 32'h06, 8, 8'h0a},
    '{5'h01, 32'h023fff55, 32, 8'h01}, '{5'h00, 32'h0500, 16, 8'h08},
    '{5'h02, 32'h06, 8, 8'h0a}, '{5'h04, 32'h04, 8, 8'h0a},
    '{5'h00, 32'h0188, 16, 8'h88}, '{5'h08, 32'h06, 8, 8'h8a},
    '{5'h18, 32'h0100, 16, 8'h88}, '{5'h00, 32'h06, 8, 8'h8a},
    '{5'h00, 32'h0100, 16, 8'h00}, '{5'h00, 32'h06, 8, 8'h02},
    '{5'h00, 32'h0104, 16, 8'h04}, '{5'h00, 32'h06, 8, 8'h06}};

  sefe_top #(.WRITE_CYCLES(16'd64)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .shift_clock, .chip_select_n, .serial_in, .pause_input_n,
    .write_guard_n, .serial_out, .serial_out_oe);
  sefe_spi_master u_spi (.shift_clock, .chip_select_n, .serial_in,
    .pause_input_n, .serial_out, .serial_out_oe);

  // compare and count
  task chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one write, each channel released when taken
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) {ta, s_axi_awvalid} <= 2'b10;
      if (s_axi_wvalid && s_axi_wready) {tw, s_axi_wvalid} <= 2'b10;
      #0 ;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read
  task axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // watchdog
  initial begin
    #400000;
    n_mismatch++;
    test_done;
  end

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, write_guard_n} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // let the idle chip select pass the synchroniser and arm the device
    repeat (8) @(posedge aclk);
    for (i = 0; i < 27; i++) begin
      write_guard_n <= !rows[i].f[3];
      @(posedge aclk);
      u_spi.xfer(rows[i].tx, rows[i].nb, rows[i].f[2:1], rx);
      if (!rows[i].f[0]) repeat (100) @(posedge aclk);
      m = rows[i].f[0] ? 8'h01 : (rows[i].f[4] ? 8'hfc : 8'hff);
      @(posedge aclk);
      axi_rd(8'h04);
      chk("status byte", d[7:0] & m, rows[i].ex);
    end
    $display("table done");
    u_spi.xfer(32'h0500, 16, 2'd0, rx);
    chk("serial status", rx[7:0], 8'h06);
    u_spi.chip_select_n = 1'b0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    u_spi.xfer(32'h06, 8, 2'd0, rx);
    repeat (20) @(posedge aclk);
    axi_rd(8'h04);
    chk("status after reset", d[7:0], 8'h04);
    $display("reset done");
    axi_wr(8'h00, 32'h1);
    axi_wr(8'h14, 32'ha5);
    u_spi.xfer(32'h83000000, 32, 2'd0, rx);
    chk("id page byte", rx[7:0], 8'ha5);
    u_spi.xfer(32'h06, 8, 2'd0, rx);
    u_spi.xfer(32'h82040000, 32, 2'd0, rx);
    repeat (100) @(posedge aclk);
    axi_rd(8'h04);
    chk("id locked", d[10], 1'b1);
    $display("id done");
    axi_rd(8'h1c);
    chk("unmapped read data", d, 32'h0);
    chk("unmapped read resp", {30'h0, r}, 32'h2);
    axi_wr(8'h1c, 32'h1);
    chk("unmapped write", r, 2'b10);
    $display("bus done");
    test_done;
  end
endmodule // sefe_top_tb
